/* File: core/asr_cfg.svh */
// register offsets, field positions, reset values and timing counts for the serial unit
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

// ****************
// register map (byte addresses)
// ****************
`define ASR_OFF_MODE 5'h00
`define ASR_OFF_RXERR 5'h04
`define ASR_OFF_TXSTAT 5'h08
`define ASR_OFF_RXBUF 5'h0c
`define ASR_OFF_TXBUF 5'h10
`define ASR_OFF_BAUD 5'h14

// ****************
// mode register fields
// ****************
`define ASR_MODE_UNITEN 7
`define ASR_MODE_TRANSMIT_ENABLE_BIT 6
`define ASR_MODE_RECEIVE_ENABLE_BIT 5
`define ASR_MODE_PAR_HI 4
`define ASR_MODE_PAR_LO 3
`define ASR_MODE_LEN8 2
`define ASR_MODE_STOP2 1
`define ASR_MODE_ROUTE 0

// ****************
// status fields
// ****************
`define ASR_ERR_PAR 2
`define ASR_ERR_FRM 1
`define ASR_ERR_OVR 0
`define ASR_TXS_FULL 1
`define ASR_TXS_BUSY 0

// ****************
// reset values
// ****************
`define ASR_RST_BUF 8'hff
`define ASR_RST_MODE 8'h01
`define ASR_RST_BAUD 16'h0015

// ****************
// timing
// ****************
`define ASR_CLK_HZ 40000000
`define ASR_OVS 16

`endif

/* File: core/asr_pkg.sv */
// types shared by the serial unit
package asr_pkg;
  typedef enum logic [1:0] {ASR_PAR_NONE = 2'b00, ASR_PAR_ZERO = 2'b01, ASR_PAR_ODD = 2'b10,
    ASR_PAR_EVEN = 2'b11} asr_par_e;
  typedef enum logic [2:0] {ASR_IDLE = 3'b000, ASR_START = 3'b001, ASR_DATA = 3'b010,
    ASR_PARITY = 3'b011, ASR_STOP = 3'b100} asr_state_e;
  typedef struct packed {
    logic unitEn;
    logic transmit_enable_bit;
    logic receive_enable_bit;
    asr_par_e parity;
    logic len8;
    logic stop2;
    logic errRoute;
  } asr_mode_s;
  typedef struct packed {
    logic rxErrorIrq;
    logic rxDoneIrq;
    logic txDoneIrq;
  } asr_irq_s;
endpackage

/* File: core/asr_serial.sv */
// full-duplex asynchronous serial unit with wishbone register access
// How it works
// - enabled receive copies frame, raises done irq
// - receive disabled: buffer kept, no irq
// - seven-bit length clears receive bit seven
// - overrun keeps previous receive buffer contents
// - receive buffer all ones on reset/unit off
// - transmit enabled: buffer write starts transmission
// - transmit disabled: buffer writes discarded
// - transmit buffer resets to all ones
// - three interrupt outputs
// - error irq is or of errors
// - no receive irqs while reception disabled
// - start, lsb-first data, parity, stop bits
// - unit disabled drives serial output high
// - buffer loads shifter, start bit first
// - done irq with last stop bit
// - reset-emptied shifter raises no done irq
// - no pending data: halt, line idle
// - next write accepted once shifting starts
// - flags go 10, 01, 11 continuously
// - busy set on load, cleared at end unless buffer full
// - full set on write, cleared on load/disable
// - reading error status clears it
// - routing bit sends errors to done irq
`timescale 1ns/100ps
`include "asr_cfg.svh"
module asr_serial #(
  parameter int OVS = `ASR_OVS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // serial pins
  input wire logic serialInPin,
  output logic serialOutPin,
  // interrupt requests
  output asr_pkg::asr_irq_s irq
);
  import asr_pkg::*;

  // ****************
  // register state
  // ****************
  asr_mode_s mode_q, mode_d;
  logic [15:0] baud_q, baud_d;
  logic [7:0] txBuf_q, txBuf_d;
  logic [7:0] rxBuf_q, rxBuf_d;
  logic [2:0] rxErr_q, rxErr_d;
  logic txFull_q, txFull_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic err_q, err_d;

  // ****************
  // baud tick, oversampled
  // ****************
  logic [15:0] bcnt_q, bcnt_d;
  logic tick;
  assign tick = (bcnt_q == 16'h0000);
  always_comb begin
    bcnt_d = (tick || !mode_q.unitEn) ? baud_q : bcnt_q - 16'h0001;
  end

  // ****************
  // transmit engine
  // ****************
  asr_state_e txSt_q, txSt_d;
  logic [7:0] txSh_q, txSh_d;
  logic [2:0] txBit_q, txBit_d;
  logic [3:0] txOs_q, txOs_d;
  logic txStop_q, txStop_d;
  logic txPar_q, txPar_d;
  logic txOut_q, txOut_d;
  logic txBusy_q, txBusy_d;
  logic txDone_q, txDone_d;
  logic txLoad;
  logic txEnd;
  logic txWrite;
  logic lastOs;
  assign lastOs = tick && (txOs_q == 4'(OVS - 1));

  always_comb begin
    txSt_d = txSt_q;
    txSh_d = txSh_q;
    txBit_d = txBit_q;
    txOs_d = tick ? txOs_q + 4'h1 : txOs_q;
    txStop_d = txStop_q;
    txPar_d = txPar_q;
    txOut_d = 1'b1;
    txBusy_d = txBusy_q;
    txDone_d = 1'b0;
    txLoad = 1'b0;
    txEnd = 1'b0;
    unique case (txSt_q)
      ASR_IDLE: begin
        txOs_d = 4'h0;
        if (txFull_q) begin
          txLoad = 1'b1;
          txSh_d = txBuf_q;
          txBusy_d = 1'b1;
          txSt_d = ASR_START;
        end
      end
      ASR_START: begin
        txOut_d = 1'b0;
        if (lastOs) begin
          txBit_d = 3'h0;
          txPar_d = mode_q.parity == ASR_PAR_ODD;
          txSt_d = ASR_DATA;
        end
      end
      ASR_DATA: begin
        txOut_d = txSh_q[0];
        if (lastOs) begin
          txSh_d = {1'b0, txSh_q[7:1]};
          txPar_d = txPar_q ^ txSh_q[0];
          txBit_d = txBit_q + 3'h1;
          if (txBit_q == (mode_q.len8 ? 3'h7 : 3'h6)) begin
            txStop_d = mode_q.stop2;
            txSt_d = (mode_q.parity == ASR_PAR_NONE) ? ASR_STOP : ASR_PARITY;
          end
        end
      end
      ASR_PARITY: begin
        txOut_d = (mode_q.parity == ASR_PAR_ZERO) ? 1'b0 : txPar_q;
        if (lastOs) begin
          txSt_d = ASR_STOP;
        end
      end
      ASR_STOP: begin
        // done raised as the final stop bit starts, so it tracks stop length
        if (tick && txOs_q == 4'h0 && !txStop_q) begin
          txDone_d = 1'b1;
        end
        if (lastOs) begin
          if (txStop_q) begin
            txStop_d = 1'b0;
          end else begin
            txEnd = 1'b1;
            txSt_d = ASR_IDLE;
            txBusy_d = txFull_q;
          end
        end
      end
      default: begin
        txSt_d = ASR_IDLE;
      end
    endcase
    if (!mode_q.unitEn || !mode_q.transmit_enable_bit) begin
      txSt_d = ASR_IDLE;
      txBusy_d = 1'b0;
      txDone_d = 1'b0;
    end
  end

  // ****************
  // receive engine, two-flop synchroniser first
  // ****************
  logic rxMeta_q, rxSync_q;
  asr_state_e rxSt_q, rxSt_d;
  logic [7:0] rxSh_q, rxSh_d;
  logic [2:0] rxBit_q, rxBit_d;
  logic [3:0] rxOs_q, rxOs_d;
  logic rxPar_q, rxPar_d;
  logic rxFrame;
  logic [2:0] rxNewErr;
  logic rxUnread_q, rxUnread_d;
  logic rxDone_q, rxDone_d;
  logic rxErrIrq_q, rxErrIrq_d;
  logic midOs;
  logic rxOn;
  assign rxOn = mode_q.unitEn && mode_q.receive_enable_bit;
  assign midOs = tick && (rxOs_q == 4'(OVS / 2 - 1));

  always_comb begin
    rxSt_d = rxSt_q;
    rxSh_d = rxSh_q;
    rxBit_d = rxBit_q;
    rxOs_d = tick ? rxOs_q + 4'h1 : rxOs_q;
    rxPar_d = rxPar_q;
    rxFrame = 1'b0;
    rxNewErr = 3'b000;
    unique case (rxSt_q)
      ASR_IDLE: begin
        rxOs_d = 4'h0;
        if (!rxSync_q) begin
          rxSt_d = ASR_START;
        end
      end
      ASR_START: begin
        if (midOs) begin
          rxOs_d = 4'h0;
          rxBit_d = 3'h0;
          rxPar_d = mode_q.parity == ASR_PAR_ODD;
          rxSt_d = rxSync_q ? ASR_IDLE : ASR_DATA;
        end
      end
      ASR_DATA: begin
        if (lastRx()) begin
          rxSh_d = {rxSync_q, rxSh_q[7:1]};
          rxPar_d = rxPar_q ^ rxSync_q;
          rxBit_d = rxBit_q + 3'h1;
          if (rxBit_q == (mode_q.len8 ? 3'h7 : 3'h6)) begin
            if (!mode_q.len8) begin
              rxSh_d = {1'b0, rxSync_q, rxSh_q[7:2]};
            end
            rxSt_d = (mode_q.parity == ASR_PAR_NONE) ? ASR_STOP : ASR_PARITY;
          end
        end
      end
      ASR_PARITY: begin
        if (lastRx()) begin
          rxPar_d = (mode_q.parity == ASR_PAR_ZERO) ? rxSync_q : rxPar_q ^ rxSync_q;
          rxSt_d = ASR_STOP;
        end
      end
      ASR_STOP: begin
        if (lastRx()) begin
          // only the first stop bit is checked
          rxFrame = 1'b1;
          rxNewErr[`ASR_ERR_PAR] = (mode_q.parity != ASR_PAR_NONE) && rxPar_q;
          rxNewErr[`ASR_ERR_FRM] = !rxSync_q;
          rxNewErr[`ASR_ERR_OVR] = rxUnread_q;
          rxSt_d = ASR_IDLE;
        end
      end
      default: begin
        rxSt_d = ASR_IDLE;
      end
    endcase
    if (!rxOn) begin
      rxSt_d = ASR_IDLE;
    end
  end

  function automatic logic lastRx();
    return tick && (rxOs_q == 4'(OVS - 1));
  endfunction

  // ****************
  // register side and buffers
  // ****************
  logic wbReq;
  logic [4:0] adr;
  assign wbReq = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign adr = {wb_adr_i[4:2], 2'b00};
  assign txWrite = wbReq && wb_we_i && wb_sel_i[0] && adr == `ASR_OFF_TXBUF;

  always_comb begin
    mode_d = mode_q;
    baud_d = baud_q;
    txBuf_d = txBuf_q;
    rxBuf_d = rxBuf_q;
    rxErr_d = rxErr_q;
    txFull_d = txFull_q;
    rxUnread_d = rxUnread_q;
    rxDone_d = 1'b0;
    rxErrIrq_d = 1'b0;
    ack_d = 1'b0;
    err_d = 1'b0;
    rdat_d = 32'h00000000;
    if (wbReq) begin
      ack_d = 1'b1;
      unique case (adr)
        `ASR_OFF_MODE: rdat_d = {24'h000000, mode_q};
        `ASR_OFF_RXERR: begin
          rdat_d = {29'h00000000, rxErr_q};
          if (!wb_we_i) begin
            rxErr_d = 3'b000;
          end
        end
        `ASR_OFF_TXSTAT: rdat_d = {30'h00000000, txFull_q, txBusy_q};
        `ASR_OFF_RXBUF: begin
          rdat_d = {24'h000000, rxBuf_q};
          if (!wb_we_i) begin
            rxUnread_d = 1'b0;
          end
        end
        `ASR_OFF_TXBUF: rdat_d = {24'h000000, txBuf_q};
        `ASR_OFF_BAUD: rdat_d = {16'h0000, baud_q};
        default: begin
          ack_d = 1'b0;
          err_d = 1'b1;
        end
      endcase
      if (wb_we_i && adr == `ASR_OFF_MODE && wb_sel_i[0]) begin
        mode_d = wb_dat_i[7:0];
      end
      if (wb_we_i && adr == `ASR_OFF_BAUD) begin
        if (wb_sel_i[0]) baud_d[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) baud_d[15:8] = wb_dat_i[15:8];
      end
    end
    if (txLoad) begin
      txFull_d = 1'b0;
    end
    if (txWrite && mode_q.unitEn && mode_q.transmit_enable_bit) begin
      txBuf_d = wb_dat_i[7:0];
      txFull_d = 1'b1;
    end
    if (!mode_q.unitEn || !mode_q.transmit_enable_bit) begin
      txFull_d = 1'b0;
    end
    if (rxFrame) begin
      // a new error beats a same-cycle read clear; bits already read stay cleared
      rxErr_d = rxErr_d | rxNewErr;
      if (!rxNewErr[`ASR_ERR_OVR]) begin
        rxBuf_d = rxSh_d;
        rxUnread_d = 1'b1;
      end
      if (|rxNewErr && !mode_q.errRoute) begin
        rxErrIrq_d = 1'b1;
      end else begin
        rxDone_d = 1'b1;
      end
    end
    if (!rxOn) begin
      rxErr_d = 3'b000;
      rxUnread_d = 1'b0;
      rxDone_d = 1'b0;
      rxErrIrq_d = 1'b0;
    end
    if (!mode_q.unitEn) begin
      rxBuf_d = `ASR_RST_BUF;
    end
  end

  // ****************
  // flip-flops
  // ****************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= `ASR_RST_MODE;
      baud_q <= `ASR_RST_BAUD;
      txBuf_q <= `ASR_RST_BUF;
      rxBuf_q <= `ASR_RST_BUF;
      rxErr_q <= 3'b000;
      txFull_q <= 1'b0;
      rxUnread_q <= 1'b0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h00000000;
      bcnt_q <= 16'h0000;
      txSt_q <= ASR_IDLE;
      txSh_q <= 8'hff;
      txBit_q <= 3'h0;
      txOs_q <= 4'h0;
      txStop_q <= 1'b0;
      txPar_q <= 1'b0;
      txOut_q <= 1'b1;
      txBusy_q <= 1'b0;
      txDone_q <= 1'b0;
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxSt_q <= ASR_IDLE;
      rxSh_q <= 8'h00;
      rxBit_q <= 3'h0;
      rxOs_q <= 4'h0;
      rxPar_q <= 1'b0;
      rxDone_q <= 1'b0;
      rxErrIrq_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      baud_q <= baud_d;
      txBuf_q <= txBuf_d;
      rxBuf_q <= rxBuf_d;
      rxErr_q <= rxErr_d;
      txFull_q <= txFull_d;
      rxUnread_q <= rxUnread_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdat_q <= rdat_d;
      bcnt_q <= bcnt_d;
      txSt_q <= txSt_d;
      txSh_q <= txSh_d;
      txBit_q <= txBit_d;
      txOs_q <= txOs_d;
      txStop_q <= txStop_d;
      txPar_q <= txPar_d;
      txOut_q <= txOut_d;
      txBusy_q <= txBusy_d;
      txDone_q <= txDone_d;
      rxMeta_q <= serialInPin;
      rxSync_q <= rxMeta_q;
      rxSt_q <= rxSt_d;
      rxSh_q <= rxSh_d;
      rxBit_q <= rxBit_d;
      rxOs_q <= rxOs_d;
      rxPar_q <= rxPar_d;
      rxDone_q <= rxDone_d;
      rxErrIrq_q <= rxErrIrq_d;
    end
  end

  // ****************
  // outputs
  // ****************
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;
  assign serialOutPin = txOut_q;
  assign irq.rxErrorIrq = rxErrIrq_q;
  assign irq.rxDoneIrq = rxDone_q;
  assign irq.txDoneIrq = txDone_q;

endmodule // asr_serial

/* File: bench/asr_serial_chk.sv */
// assertion checker bound to the serial unit's ports
`timescale 1ns/100ps
module asr_serial_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // pins and requests
  input wire logic serialOutPin,
  input wire asr_pkg::asr_irq_s irq
);
  import asr_pkg::*;
  // ****
  // mode shadow, taken at the ack of a write
  // ****
  asr_mode_s modeQ;
  asr_mode_s modeD;
  always_comb begin
    modeD = modeQ;
    if (wb_ack_o && wb_we_i && wb_adr_i[4:2] == 3'h0 && wb_sel_i[0]) begin
      modeD = asr_mode_s'(wb_dat_i[7:0]);
    end
  end
  always_ff @(posedge core_clk) begin
    modeQ <= rst ? asr_mode_s'(8'h01) : modeD;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence reqOpen;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence stopHeld;
    serialOutPin [*4];
  endsequence
  chk_ack_next: assert property (reqOpen |=> wb_ack_o || wb_err_o)
    else $error("bus request not answered");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_err_unmapped: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    && wb_adr_i[4:3] == 2'b11 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  chk_reset_idle: assert property (disable iff (1'b0) $fell(rst) |-> serialOutPin && irq == '0)
    else $error("line or requests wrong after reset");
  chk_tx_stop: assert property (irq.txDoneIrq |-> ##1 stopHeld)
    else $error("transmit done not in stop bit");
  chk_tx_off_idle: assert property (!modeQ.transmit_enable_bit |-> ##2 serialOutPin)
    else $error("line active with transmit off");
  chk_rx_off_quiet: assert property (!modeQ.receive_enable_bit |-> !irq.rxDoneIrq && !irq.rxErrorIrq)
    else $error("receive request while receive off");
  chk_route_done: assert property (modeQ.errRoute |-> !irq.rxErrorIrq)
    else $error("error request despite routing");
  chk_rx_one_irq: assert property (!(irq.rxDoneIrq && irq.rxErrorIrq))
    else $error("both receive requests at once");
  chk_irq_pulse: assert property ($rose(irq.rxDoneIrq) |=> !irq.rxDoneIrq)
    else $error("receive done not a pulse");
endmodule // asr_serial_chk
bind asr_serial asr_serial_chk chkI (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .serialOutPin, .irq);

/* File: bench/asr_remote.sv */
// remote serial transceiver model facing the unit's pins
`timescale 1ns/100ps
module asr_remote #(
  parameter int BIT = 16
) (
  // clock
  input wire logic core_clk,
  // serial lines
  input wire logic txLine,
  output logic rxLine
);
  int nBits = 8;
  int frames = 0;
  logic [8:0] word = 9'h000;
  logic stopBit = 1'b0;
  // ****
  // sender: line rests high between frames, as a pulled-up link
  // ****
  initial rxLine = 1'b1;
  task automatic sendFrame(input logic [8:0] d, input int n, input logic stopV);
    @(posedge core_clk);
    rxLine <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (BIT) @(posedge core_clk);
      rxLine <= (i == n) ? stopV : d[i];
    end
    repeat (BIT) @(posedge core_clk);
    rxLine <= 1'b1;
  endtask
  // ****
  // receiver: samples mid-bit on the falling clock to avoid races
  // ****
  always begin
    @(negedge txLine);
    repeat (BIT / 2) @(negedge core_clk);
    for (int i = 0; i < nBits; i++) begin
      repeat (BIT) @(negedge core_clk);
      word[i] = txLine;
    end
    repeat (BIT) @(negedge core_clk);
    stopBit = txLine;
    frames++;
  end
endmodule // asr_remote

/* File: bench/asr_serial_tb_top.sv */
// self-checking bench for the serial unit
`timescale 1ns/100ps
module asr_serial_tb_top;
  import asr_pkg::*;
  localparam int BIT = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, wbErr, serialIn, serialOut;
  logic [4:0] wbAdr = 5'h00;
  logic [31:0] wbDatI = 32'h0, wbDatO;
  asr_irq_s irq;
  int bad_count = 0, num_checks = 0, nDone = 0, nErr = 0, nTx = 0;
  always #12.5 core_clk = ~core_clk;
  asr_serial dut (.core_clk, .rst, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .wb_err_o(wbErr), .serialInPin(serialIn), .serialOutPin(serialOut), .irq);
  asr_remote #(.BIT(BIT)) peer (.core_clk, .txLine(serialOut), .rxLine(serialIn));
  always @(posedge core_clk) begin
    if (irq.rxDoneIrq === 1'b1) nDone++;
    if (irq.rxErrorIrq === 1'b1) nErr++;
    if (irq.txDoneIrq === 1'b1) nTx++;
  end
  // ****
  // helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkN(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  // refused access reads back as ee so it can be compared
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= {24'h0, d};
    do @(posedge core_clk); while (wbAck !== 1'b1 && wbErr !== 1'b1);
    q = (wbErr === 1'b1) ? 8'hee : wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic waitTx(input int n);
    for (int k = 0; k < 4000 && peer.frames < n; k++) @(posedge core_clk);
    repeat (BIT) @(posedge core_clk);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rd(5'h0c, 8'hff);
    rd(5'h10, 8'hff);
    rd(5'h18, 8'hee);
    wr(5'h14, 8'h00);
  endtask
  task automatic t_tx();
    wr(5'h00, 8'hc4);
    wr(5'h10, 8'h35);
    rd(5'h08, 8'h01);
    wr(5'h10, 8'ha6);
    rd(5'h08, 8'h03);
    waitTx(1);
    chk(peer.word[7:0], 8'h35);
    waitTx(2);
    chk(peer.word[7:0], 8'ha6);
    chk({7'h0, peer.stopBit}, 8'h01);
    chkN(nTx, 2);
    rd(5'h08, 8'h00);
    chk({7'h0, serialOut}, 8'h01);
  endtask
  task automatic t_tx_off();
    wr(5'h00, 8'h84);
    wr(5'h10, 8'h5a);
    rd(5'h08, 8'h00);
    rd(5'h10, 8'ha6);
    repeat (4 * BIT) @(posedge core_clk);
    chkN(peer.frames, 2);
  endtask
  task automatic t_parity();
    peer.nBits = 9;
    for (int p = 1; p < 4; p++) begin
      wr(5'h00, {3'b110, 2'(p), 3'b100});
      wr(5'h10, 8'h07);
      waitTx(2 + p);
      chk({7'h0, peer.word[8]}, {7'h0, p == 3});
    end
    peer.nBits = 8;
  endtask
  task automatic t_rx();
    logic [7:0] q;
    wr(5'h00, 8'ha4);
    peer.sendFrame(9'h03c, 8, 1'b1);
    chkN(nDone, 1);
    rd(5'h0c, 8'h3c);
    peer.sendFrame(9'h0f0, 8, 1'b0);
    chkN(nErr, 1);
    rd(5'h04, 8'h02);
    rd(5'h04, 8'h00);
    bus(1'b0, 5'h0c, 8'h00, q);
    peer.sendFrame(9'h011, 8, 1'b1);
    peer.sendFrame(9'h022, 8, 1'b1);
    rd(5'h04, 8'h01);
    rd(5'h0c, 8'h11);
  endtask
  task automatic t_rx_off();
    wr(5'h00, 8'h84);
    peer.sendFrame(9'h055, 8, 1'b1);
    chkN(nDone, 2);
    rd(5'h0c, 8'h11);
  endtask
  task automatic t_rx7();
    wr(5'h00, 8'ha1);
    peer.sendFrame(9'h0ff, 7, 1'b1);
    rd(5'h0c, 8'h7f);
    peer.sendFrame(9'h000, 7, 1'b0);
    chkN(nDone, 4);
    chkN(nErr, 2);
    wr(5'h00, 8'h00);
    rd(5'h0c, 8'hff);
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_tx_off();
    t_parity();
    t_rx();
    t_rx_off();
    t_rx7();
    end_of_test();
  end
endmodule // asr_serial_tb_top
